// file: csg_defines.svh
// Constants for the clock selector, output gate and fanout block.
`ifndef CSG_DEFINES_SVH
`define CSG_DEFINES_SVH

`define CSG_NUM_OUTPUTS     5
`define CSG_SYNC_STAGES     2
`define CSG_SEL_PRIMARY     1'h1
`define CSG_SEL_ALT         1'h0
`define CSG_GATE_ENABLED    1'h0
`define CSG_STD_LVDS        1'h0
`define CSG_STD_LVPECL      1'h1
`define CSG_RST_TRUE_LEVEL  1'h0
`define CSG_RST_COMP_LEVEL  1'h1

`endif

// file: csg_pkg.sv
// Types shared by the clock selector, output gate and fanout block.
package csg_pkg;

  typedef struct packed {
    logic tru;
    logic comp;
  } csg_diff_s;

  typedef enum logic {
    CSG_LVDS,
    CSG_LVPECL
  } csg_std_e;

endpackage : csg_pkg

// file: csg_fanout.sv
// Clock selector with synchronising output gate and fanout to differential pairs.
// Behaviour
// - A high input-pair select routes the primary pair to the outputs, a low one the alternate pair.
// - While the gate input is low, every output pair reproduces the selected input clock.
// - While the gate input is high, every true output is low and every complement output is high.
// - A change of the gate input reaches the outputs only at the next falling edge of the selected input clock.
// - Enabled outputs follow the selected input without inversion.
// - The output standard select picks LVDS when low, the default, and LVPECL when high.
`timescale 1ns/10ps
`include "csg_defines.svh"

module csg_fanout #(
  parameter int NUM_OUT = `CSG_NUM_OUTPUTS
) (
  input  wire logic               CLK,
  input  wire logic               SRST,
  input  wire csg_pkg::csg_diff_s PRIMARY_CLOCK_IN,
  input  wire csg_pkg::csg_diff_s ALT_CLOCK_IN,
  input  wire logic               INPUT_SELECT,
  input  wire logic               OUTPUT_GATE_N,
  input  wire logic               OUTPUT_STD_SELECT,
  output logic [NUM_OUT-1:0]      FANOUT_TRUE,
  output logic [NUM_OUT-1:0]      FANOUT_COMP,
  output csg_pkg::csg_std_e       OUTPUT_STD,
  output logic                    OUTPUTS_ACTIVE
);
  import csg_pkg::*;

  // Reset and gated-off state of a pair: true low, complement high.
  localparam csg_diff_s PAIR_LOW = '{tru: `CSG_RST_TRUE_LEVEL, comp: `CSG_RST_COMP_LEVEL};

  if (NUM_OUT < 1) begin : g_bad_num_out
    $error("csg_fanout: NUM_OUT must be at least one");
  end

  // The chains below are written out with exactly two stages each.
  if (`CSG_SYNC_STAGES != 2) begin : g_bad_sync_stages
    $error("csg_fanout: the synchronisers are built for two stages");
  end

  // Every input pin but SRST is asynchronous to CLK, so each passes two flip-flops before any
  // logic reads it; only the second stage of a chain is ever read.
  csg_diff_s prim_s1_r;
  csg_diff_s prim_s2_r;
  csg_diff_s alt_s1_r;
  csg_diff_s alt_s2_r;
  logic      sel_s1_r;
  logic      sel_s2_r;
  logic      gate_n_s1_r;
  logic      gate_n_s2_r;
  logic      std_s1_r;
  logic      std_s2_r;

  // Decoded level of the selected input and its falling edge.
  logic      lvl_r;
  logic      lvl_nxt;
  logic      falling;

  // Gate state: high while the outputs follow the selected clock.
  logic      gate_en_r;
  logic      gate_en_nxt;

  // Next output pair and next reported standard, registered below.
  csg_diff_s pair_nxt;
  csg_std_e  std_nxt;

  // Primary input pair.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      prim_s1_r <= PAIR_LOW;
      prim_s2_r <= PAIR_LOW;
    end else begin
      prim_s1_r <= PRIMARY_CLOCK_IN;
      prim_s2_r <= prim_s1_r;
    end
  end

  // Alternate input pair.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      alt_s1_r <= PAIR_LOW;
      alt_s2_r <= PAIR_LOW;
    end else begin
      alt_s1_r <= ALT_CLOCK_IN;
      alt_s2_r <= alt_s1_r;
    end
  end

  // Input-pair select. It resets to the alternate pair, the level that an
  // undriven select pin settles to.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      sel_s1_r <= `CSG_SEL_ALT;
      sel_s2_r <= `CSG_SEL_ALT;
    end else begin
      sel_s1_r <= INPUT_SELECT;
      sel_s2_r <= sel_s1_r;
    end
  end

  // Gate pin. It resets to the closed level, so nothing reaches the outputs
  // before the first decoded fall after reset.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      gate_n_s1_r <= ~`CSG_GATE_ENABLED;
      gate_n_s2_r <= ~`CSG_GATE_ENABLED;
    end else begin
      gate_n_s1_r <= OUTPUT_GATE_N;
      gate_n_s2_r <= gate_n_s1_r;
    end
  end

  // Output standard select. It resets to LVDS, the default standard, and is
  // not tied to the gate because it only chooses levels, not timing.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      std_s1_r <= `CSG_STD_LVDS;
      std_s2_r <= `CSG_STD_LVDS;
    end else begin
      std_s1_r <= OUTPUT_STD_SELECT;
      std_s2_r <= std_s1_r;
    end
  end

  // Resolves a pair to a level; an equal pair is not a valid differential
  // state, so the previous level is kept rather than guessing one.
  function automatic logic diff_level(input csg_diff_s pair, input logic prev);
    logic lvl;
    lvl = prev;
    if (pair.tru && !pair.comp) begin
      lvl = 1'h1;
    end else if (!pair.tru && pair.comp) begin
      lvl = 1'h0;
    end
    return lvl;
  endfunction : diff_level

  // The select is not resynchronised to the selected clock, so a change while
  // the outputs run may cut a pulse; the gate should be closed first.
  always_comb begin
    if (sel_s2_r == `CSG_SEL_PRIMARY) begin
      lvl_nxt = diff_level(prim_s2_r, lvl_r);
    end else begin
      lvl_nxt = diff_level(alt_s2_r, lvl_r);
    end
  end

  assign falling = lvl_r & ~lvl_nxt;

  // The gate only moves while the selected clock goes low, which is the
  // phase in which the outputs are low either way, so no pulse is cut.
  always_comb begin
    gate_en_nxt = gate_en_r;
    if (falling) begin
      gate_en_nxt = (gate_n_s2_r == `CSG_GATE_ENABLED);
    end
  end

  // Decoded level of the selected clock, the reference for fall detection.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      lvl_r <= 1'h0;
    end else begin
      lvl_r <= lvl_nxt;
    end
  end

  // Gate state; it only ever moves in a cycle that carries a fall.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      gate_en_r <= 1'h0;
    end else begin
      gate_en_r <= gate_en_nxt;
    end
  end

  // Next output pair. The output register uses the gate state of the same
  // edge, so the cycle in which the gate moves already shows the new state.
  always_comb begin
    if (gate_en_nxt) begin
      pair_nxt = '{tru: lvl_nxt, comp: ~lvl_nxt};
    end else begin
      pair_nxt = PAIR_LOW;
    end
  end

  // All lanes are copies of one pair; the complement is always the inverse.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      FANOUT_TRUE <= {NUM_OUT{PAIR_LOW.tru}};
      FANOUT_COMP <= {NUM_OUT{PAIR_LOW.comp}};
    end else begin
      FANOUT_TRUE <= {NUM_OUT{pair_nxt.tru}};
      FANOUT_COMP <= {NUM_OUT{pair_nxt.comp}};
    end
  end

  // Reports whether the gate is open, in step with the output register, so a
  // receiver can tell a held-low output from a slow input clock.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      OUTPUTS_ACTIVE <= 1'h0;
    end else begin
      OUTPUTS_ACTIVE <= gate_en_nxt;
    end
  end

  // The standard is only reported here; the electrical levels are outside
  // this logic, so a change takes effect on the next edge without any gating.
  always_comb begin
    if (std_s2_r == `CSG_STD_LVPECL) begin
      std_nxt = CSG_LVPECL;
    end else begin
      std_nxt = CSG_LVDS;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      OUTPUT_STD <= CSG_LVDS;
    end else begin
      OUTPUT_STD <= std_nxt;
    end
  end

endmodule : csg_fanout

// file: csg_src_model.sv
// Behavioural source for one differential clock pair.
`timescale 1ns/10ps
module csg_src #(parameter int HALF = 3) (
  input logic CLK,
  input logic SRST,
  output csg_pkg::csg_diff_s pair
);
  int c = 0;
  // Parked low in reset so that the release shows no stale fall.
  always @(negedge CLK) begin
    c <= (SRST || c == HALF - 1) ? 0 : c + 1;
    if (SRST || c == HALF - 1) pair <= SRST ? 2'h1 : ~pair;
  end
endmodule : csg_src

// file: csg_fanout_chk.sv
// Port assertions for the clock fanout block.
`timescale 1ns/10ps
module csg_fanout_chk #(parameter int NUM_OUT = 5) (
  input logic CLK,
  input logic SRST,
  input csg_pkg::csg_diff_s PRIMARY_CLOCK_IN,
  input csg_pkg::csg_diff_s ALT_CLOCK_IN,
  input logic INPUT_SELECT,
  input logic OUTPUT_GATE_N,
  input logic OUTPUT_STD_SELECT,
  input logic [NUM_OUT-1:0] FANOUT_TRUE,
  input logic [NUM_OUT-1:0] FANOUT_COMP,
  input csg_pkg::csg_std_e OUTPUT_STD,
  input logic OUTPUTS_ACTIVE
);
  wire p = INPUT_SELECT ? PRIMARY_CLOCK_IN.tru : ALT_CLOCK_IN.tru;
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  run_follow_a: assert property (OUTPUTS_ACTIVE |->
    FANOUT_TRUE == {NUM_OUT{$past(p, 3)}}) else $error("bad level");
  gated_low_a: assert property (!OUTPUTS_ACTIVE |-> !FANOUT_TRUE)
    else $error("gated high");
  comp_inverse_a: assert property (FANOUT_COMP == ~FANOUT_TRUE)
    else $error("bad complement");
  gate_fall_a: assert property ($changed(OUTPUTS_ACTIVE) |->
    $past(p, 4) && !$past(p, 3)) else $error("gate off fall");
  gate_level_a: assert property ($changed(OUTPUTS_ACTIVE) |->
    OUTPUTS_ACTIVE != $past(OUTPUT_GATE_N, 3)) else $error("bad gate");
  std_follow_a: assert property (OUTPUT_STD == $past(OUTPUT_STD_SELECT, 3))
    else $error("bad standard");
endmodule : csg_fanout_chk
bind csg_fanout csg_fanout_chk #(.NUM_OUT(NUM_OUT)) csg_fanout_chk_inst (
  .CLK(CLK), .SRST(SRST), .PRIMARY_CLOCK_IN(PRIMARY_CLOCK_IN), .ALT_CLOCK_IN(ALT_CLOCK_IN),
  .INPUT_SELECT(INPUT_SELECT), .OUTPUT_GATE_N(OUTPUT_GATE_N),
  .OUTPUT_STD_SELECT(OUTPUT_STD_SELECT), .FANOUT_TRUE(FANOUT_TRUE),
  .FANOUT_COMP(FANOUT_COMP), .OUTPUT_STD(OUTPUT_STD), .OUTPUTS_ACTIVE(OUTPUTS_ACTIVE));

// file: csg_fanout_bench.sv
// Random bench for the clock fanout block.
`timescale 1ns/10ps
module csg_fanout_bench;
  import csg_pkg::*;
  logic CLK = 0, SRST = 1, INPUT_SELECT = 0, OUTPUT_GATE_N = 1, OUTPUT_STD_SELECT = 0;
  logic ea, OUTPUTS_ACTIVE;
  csg_diff_s PRIMARY_CLOCK_IN, ALT_CLOCK_IN;
  logic [4:0] FANOUT_TRUE, FANOUT_COMP;
  csg_std_e OUTPUT_STD;
  logic [3:0] d = 0, g = 0, s = 0;
  logic [11:0] e, q[$];
  wire [11:0] seen = {OUTPUTS_ACTIVE, FANOUT_TRUE, FANOUT_COMP, OUTPUT_STD};
  int seed = 31, errors = 0, total_checks = 0;
  initial forever #5 CLK = ~CLK;
  csg_src #(3) fast_inst (.CLK, .SRST, .pair(PRIMARY_CLOCK_IN));
  csg_src #(5) slow_inst (.CLK, .SRST, .pair(ALT_CLOCK_IN));
  csg_fanout csg_fanout_inst (
    .CLK(CLK), .SRST(SRST), .PRIMARY_CLOCK_IN(PRIMARY_CLOCK_IN), .ALT_CLOCK_IN(ALT_CLOCK_IN),
    .INPUT_SELECT(INPUT_SELECT), .OUTPUT_GATE_N(OUTPUT_GATE_N),
    .OUTPUT_STD_SELECT(OUTPUT_STD_SELECT), .FANOUT_TRUE(FANOUT_TRUE),
    .FANOUT_COMP(FANOUT_COMP), .OUTPUT_STD(OUTPUT_STD), .OUTPUTS_ACTIVE(OUTPUTS_ACTIVE));
  // Pins show two edges late; the gate moves only where that level falls.
  always @(posedge CLK) begin
    d = {d[2:0], INPUT_SELECT ? PRIMARY_CLOCK_IN.tru : ALT_CLOCK_IN.tru};
    g = {g[2:0], OUTPUT_GATE_N};
    s = {s[2:0], OUTPUT_STD_SELECT};
    ea = !SRST && (d[3] && !d[2] ? !g[2] : ea);
    q.push_back({ea, {5{ea & d[2]}}, {5{!(ea & d[2])}}, s[2]});
  end
  always @(posedge CLK) begin
    #1 e = q.pop_front();
    total_checks++;
    if (seen !== e) begin
      errors++;
      $display("unexpected outputs: expected %h seen %h", e, seen);
    end
  end
  task give_verdict;
    $display("%0d checks, %0d errors", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (8) @(negedge CLK);
    SRST <= 0;
    repeat (3000) @(negedge CLK) begin
      if ($random(seed) % 12 == 0) OUTPUT_GATE_N = ~OUTPUT_GATE_N;
      if (OUTPUT_GATE_N && !OUTPUTS_ACTIVE) INPUT_SELECT = 1'($random(seed));
      OUTPUT_STD_SELECT = 1'($random(seed));
    end
    give_verdict;
  end
  initial begin
    #40000 errors++;
    give_verdict;
  end
endmodule : csg_fanout_bench
